// >>> mje_exec.sv
/*
 * Execution unit for data-move and program-control instructions: register
 * transfers, loads and stores over a word-wide memory port, the addressed
 * register file, conditional stores, address resolution and jumps.
 * Assumes the sequencer presents one instruction at a time with i_start while
 * o_busy is low, together with the formed effective address, and that memory
 * answers each request with a one-cycle i_mem_ack.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mje_defs.svh"

module mje_exec
   import mje_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_start,
   input  wire mje_op_e    i_op,
   input  wire logic[31:0] i_ea,
   input  wire logic[31:0] i_pc_next,
   input  wire logic[1:0]  i_ring,
   input  wire logic[1:0]  i_reg_set,
   input  wire mje_mode_e  i_addr_mode,
   input  wire logic       i_double_mode,
   input  wire logic       i_index_req,
   input  wire logic       i_restricted,
   input  wire logic       i_mem_ack,
   input  wire logic[15:0] i_mem_rdata,
   output var mje_mem_req_s o_mem,
   output var mje_regs_s   o_regs,
   output logic[31:0]      o_pc,
   output logic            o_busy,
   output logic            o_done,
   output logic            o_illegal,
   output logic            o_cc_eq,
   output logic            o_int_inhibit
);
   // ***************************************************************
   // reset release
   // ***************************************************************
   logic rst_q1;
   logic rst_n;
   // asynchronous assert, release after two edges
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   // ***************************************************************
   // state
   // ***************************************************************
   mje_state_e  state,  next_state;
   mje_op_e     op,     next_op;
   mje_regs_s   regs,   next_regs;
   logic [31:0] ea,     next_ea;
   logic [31:0] pc,     next_pc;
   logic [31:0] ret,    next_ret;
   logic        idx,    next_idx;
   logic [15:0] rd0,    next_rd0;
   logic [15:0] rd1,    next_rd1;
   logic [15:0] wd0,    next_wd0;
   logic [15:0] wd1,    next_wd1;
   logic        done,   next_done;
   logic        ill,    next_ill;
   logic        cc_eq,  next_cc_eq;
   logic        inh,    next_inh;
   logic        rf_we;
   logic [6:0]  rf_sel;
   logic [31:0] rf [`MJE_RF_DEPTH];
   logic [15:0] mask;
   logic        wide;
   logic        bad_now;
   logic [15:0] a_sel;

   // addressing-mode mask for address fields and return truncation
   always_comb begin
      unique case (i_addr_mode)
         mode_16s: mask = `MJE_MASK_16S;
         mode_64r: mask = `MJE_MASK_64R;
         default:  mask = `MJE_MASK_32;
      endcase
   end

   // two-word operations walk the pair high word first
   assign wide = (op == op_double_load) || (op == op_double_store) || (op == op_long_load)
              || (op == op_long_store) || (op == op_conditional_long_store);

   // register-file entry from the word number, by ring
   always_comb begin
      if (i_ring != 2'b00) begin
         rf_sel = {i_reg_set, 1'b0, i_ea[3:0]};
      end else if (i_ea[`MJE_ABS_SEL_BIT]) begin
         rf_sel = i_ea[6:0];
      end else begin
         rf_sel = {i_reg_set, i_ea[4:0]};
      end
   end

   // decode-time refusals; the a, b, x, y and e registers are left unchanged when one hits
   always_comb begin
      bad_now = 1'b0;
      unique case (i_op)
         op_double_load, op_double_store: bad_now = !i_double_mode;
         op_index_load, op_index_store, op_y_load, op_y_store: bad_now = i_index_req;
         op_store_to_addressed_register, op_load_from_addressed_register:
            bad_now = (i_ring != 2'b00) && ((i_ea[15:0] & `MJE_RING_HI_MSK) != 16'h0000);
         default: bad_now = 1'b0;
      endcase
   end

   assign a_sel = regs.a & mask;

   // ***************************************************************
   // next-state logic
   // ***************************************************************
   always_comb begin
      next_state = state;
      next_op    = op;
      next_regs  = regs;
      next_ea    = ea;
      next_pc    = pc;
      next_ret   = ret;
      next_idx   = idx;
      next_rd0   = rd0;
      next_rd1   = rd1;
      next_wd0   = wd0;
      next_wd1   = wd1;
      next_done  = 1'b0;
      next_ill   = 1'b0;
      next_cc_eq = cc_eq;
      // inhibit outlives the jump's own done; it drops after the next instruction ends
      next_inh   = (done && (op != op_jump_and_store_return)) ? 1'b0 : inh;
      rf_we      = 1'b0;
      unique case (state)
         st_idle: begin
            if (i_start) begin
               next_op   = i_op;
               next_ea   = i_ea;
               next_ret  = i_pc_next;
               next_pc   = i_pc_next;
               next_idx  = 1'b0;
               next_done = 1'b1;
               if (bad_now) begin
                  next_ill = 1'b1;
               end else begin
                  unique case (i_op)
                     op_move_a_to_b:     next_regs.b = regs.a;
                     op_move_b_to_a:     next_regs.a = regs.b;
                     op_move_a_to_index: next_regs.x = regs.a;
                     op_move_index_to_a: next_regs.a = regs.x;
                     op_move_a_to_y:     next_regs.y = regs.a;
                     op_move_y_to_a:     next_regs.a = regs.y;
                     op_long_exchange: begin
                        {next_regs.a, next_regs.b} = regs.e;
                        next_regs.e = {regs.a, regs.b};
                     end
                     op_store_to_addressed_register: rf_we = 1'b1;
                     op_load_from_addressed_register: {next_regs.a, next_regs.b} = rf[rf_sel];
                     op_unconditional_jump: next_pc = i_ea;
                     op_jump_if_zero:         if (regs.a == 16'h0000) next_pc = i_ea;
                     op_jump_if_nonzero:      if (regs.a != 16'h0000) next_pc = i_ea;
                     op_jump_if_not_positive: if ($signed(regs.a) <= 0) next_pc = i_ea;
                     op_jump_if_positive:     if ($signed(regs.a) > 0) next_pc = i_ea;
                     op_jump_if_negative:     if (regs.a[15]) next_pc = i_ea;
                     op_jump_if_not_negative: if (!regs.a[15]) next_pc = i_ea;
                     op_decrement_index_jump: begin
                        next_regs.x = regs.x - 16'h0001;
                        if (regs.x != 16'h0001) next_pc = i_ea;
                     end
                     op_increment_index_jump: begin
                        next_regs.x = regs.x + 16'h0001;
                        if (regs.x != 16'hFFFF) next_pc = i_ea;
                     end
                     op_compute_address: begin
                        // indirect chain only where the mode has an indirect bit
                        if (regs.a[`MJE_IND_BIT] && (i_addr_mode != mode_64r)) begin
                           next_ea    = {i_ea[31:16], a_sel};
                           next_state = st_read;
                           next_done  = 1'b0;
                        end else begin
                           next_regs.a = a_sel;
                        end
                     end
                     op_index_store, op_double_store, op_long_store, op_y_store: begin
                        next_wd0   = (i_op == op_index_store) ? regs.x :
                                     (i_op == op_y_store) ? regs.y : regs.a;
                        next_wd1   = regs.b;
                        next_state = st_write;
                        next_done  = 1'b0;
                     end
                     default: begin
                        next_state = st_read;
                        next_done  = 1'b0;
                     end
                  endcase
               end
            end
         end
         st_read: begin
            if (i_mem_ack) begin
               if (idx) next_rd1 = i_mem_rdata;
               else     next_rd0 = i_mem_rdata;
               if (wide && !idx) next_idx = 1'b1;
               else              next_state = st_exec;
            end
         end
         st_exec: begin
            next_idx   = 1'b0;
            next_state = st_idle;
            next_done  = 1'b1;
            unique case (op)
               op_index_load: next_regs.x = rd0;
               op_y_load:     next_regs.y = rd0;
               op_double_load, op_long_load: {next_regs.a, next_regs.b} = {rd0, rd1};
               op_conditional_short_store: begin
                  next_cc_eq = (rd0 == regs.b);
                  if (rd0 == regs.b) begin
                     next_wd0   = regs.a;
                     next_state = st_write;
                     next_done  = 1'b0;
                  end
               end
               op_conditional_long_store: begin
                  next_cc_eq = ({rd0, rd1} == regs.e);
                  if ({rd0, rd1} == regs.e) begin
                     next_wd0   = regs.a;
                     next_wd1   = regs.b;
                     next_state = st_write;
                     next_done  = 1'b0;
                  end
               end
               op_jump_and_store_return: begin
                  next_wd0   = (rd0 & ~mask) | (ret[15:0] & mask);
                  next_state = st_write;
                  next_done  = 1'b0;
               end
               op_compute_address: begin
                  if (rd0[`MJE_IND_BIT] && (i_addr_mode != mode_64r)) begin
                     next_ea    = {ea[31:16], rd0 & mask};
                     next_state = st_read;
                     next_done  = 1'b0;
                  end else begin
                     next_regs.a = rd0 & mask;
                  end
               end
               default: next_regs = regs;
            endcase
         end
         st_write: begin
            if (i_mem_ack) begin
               if (wide && !idx) begin
                  next_idx = 1'b1;
               end else begin
                  next_state = st_idle;
                  next_done  = 1'b1;
                  if (op == op_jump_and_store_return) begin
                     next_pc  = ea + 32'h0000_0001;
                     next_inh = !i_restricted;
                  end
               end
            end
         end
         default: next_state = st_idle;
      endcase
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= st_idle;
         op    <= op_move_a_to_b;
         regs  <= '0;
         ea    <= `MJE_RST_LONG;
         pc    <= `MJE_RST_LONG;
         ret   <= `MJE_RST_LONG;
         idx   <= 1'b0;
         rd0   <= `MJE_RST_WORD;
         rd1   <= `MJE_RST_WORD;
         wd0   <= `MJE_RST_WORD;
         wd1   <= `MJE_RST_WORD;
         done  <= 1'b0;
         ill   <= 1'b0;
         cc_eq <= 1'b0;
         inh   <= 1'b0;
      end else begin
         state <= next_state;
         op    <= next_op;
         regs  <= next_regs;
         ea    <= next_ea;
         pc    <= next_pc;
         ret   <= next_ret;
         idx   <= next_idx;
         rd0   <= next_rd0;
         rd1   <= next_rd1;
         wd0   <= next_wd0;
         wd1   <= next_wd1;
         done  <= next_done;
         ill   <= next_ill;
         cc_eq <= next_cc_eq;
         inh   <= next_inh;
      end
   end

   // register file entries; no reset, software initialises them
   genvar g;
   generate
      for (g = 0; g < `MJE_RF_DEPTH; g++) begin : g_rf
         always_ff @(posedge i_clk) begin
            if (rf_we && (rf_sel == 7'(g))) begin
               rf[g] <= {regs.a, regs.b};
            end
         end
      end
   endgenerate

   // ***************************************************************
   // outputs
   // ***************************************************************
   // lock spans read, compare and write so no channel slips between them
   assign o_mem.valid = (state == st_read) || (state == st_write);
   assign o_mem.write = (state == st_write);
   assign o_mem.lock  = (state != st_idle) && ((op == op_conditional_short_store)
                     || (op == op_conditional_long_store));
   assign o_mem.addr  = {ea[31:16], ea[15:0] + {15'h0000, idx}};
   assign o_mem.wdata = idx ? wd1 : wd0;
   assign o_regs        = regs;
   assign o_pc          = pc;
   assign o_busy        = (state != st_idle);
   assign o_done        = done;
   assign o_illegal     = ill;
   assign o_cc_eq       = cc_eq;
   assign o_int_inhibit = inh;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   sequence take_s(mje_op_e o);
      (state == st_idle) && i_start && (i_op == o) && !bad_now;
   endsequence
   sequence exec_s(mje_op_e o);
      (state == st_exec) && (op == o);
   endsequence

   dbl_refused_a: assert property ((state == st_idle) && i_start && !i_double_mode && (i_op == op_double_load)
      |=> o_illegal && o_done && (regs == $past(regs)))
      else $error("double op outside double mode not refused");
   move_ab_a: assert property (take_s(op_move_a_to_b) |=> (regs.b == $past(regs.a)) && o_done)
      else $error("a to b transfer wrong");
   exch_le_a: assert property (take_s(op_long_exchange)
      |=> (regs.e == {$past(regs.a), $past(regs.b)}) && !o_busy)
      else $error("long exchange wrong");
   cas_write_a: assert property (exec_s(op_conditional_short_store) && (rd0 == regs.b)
      |=> o_mem.write && o_mem.lock && (o_mem.wdata == $past(regs.a)) && o_cc_eq)
      else $error("conditional store did not write");
   cas_skip_a: assert property (exec_s(op_conditional_short_store) && (rd0 != regs.b)
      |=> !o_mem.valid && o_done && !o_cc_eq)
      else $error("conditional store wrote on mismatch");
   lock_span_a: assert property (take_s(op_conditional_long_store)
      |=> o_mem.lock throughout (o_busy [*2]))
      else $error("interlock dropped");
   jst_return_a: assert property (o_done && (op == op_jump_and_store_return) && !ill
      |-> (o_pc == ea + 32'h0000_0001) && (o_int_inhibit == !$past(i_restricted)))
      else $error("jump and store return wrong");
   dec_jump_a: assert property (take_s(op_decrement_index_jump)
      |=> (regs.x == $past(regs.x) - 16'h0001)
          && (o_pc == ((regs.x != 16'h0000) ? $past(i_ea) : $past(i_pc_next))))
      else $error("decrement and jump wrong");
   jump_zero_a: assert property (take_s(op_jump_if_zero)
      |=> o_pc == (($past(regs.a) == 16'h0000) ? $past(i_ea) : $past(i_pc_next)))
      else $error("jump on zero wrong");
   inh_hold_a: assert property (o_int_inhibit && !o_done && !o_busy |=> o_int_inhibit)
      else $error("interrupt inhibit dropped early");
endmodule : mje_exec
`default_nettype wire

// >>> mje_defs.svh
/*
 * Constants for the move and jump execution unit: widths, field positions,
 * masks and reset values.
 * Assumes it is included by the package and the unit; it defines macros only.
 */
`ifndef MJE_DEFS_SVH
`define MJE_DEFS_SVH

// ***************************************************************
// sizes and reset values
// ***************************************************************
`define MJE_WORD_W      16
`define MJE_RF_DEPTH    128
`define MJE_RF_IDX_W    7
`define MJE_RST_WORD    16'h0000
`define MJE_RST_LONG    32'h0000_0000

// ***************************************************************
// address word fields (bit 15 is the msb, bit 0 the lsb)
// ***************************************************************
`define MJE_IND_BIT     15
`define MJE_ABS_SEL_BIT 14
`define MJE_MASK_16S    16'h3FFF
`define MJE_MASK_32     16'h7FFF
`define MJE_MASK_64R    16'hFFFF
`define MJE_RING_HI_MSK 16'hFFF0

`endif

// >>> mje_pkg.sv
/*
 * Types of the move and jump execution unit: operation codes, addressing
 * modes, states and the carriers for registers and memory requests.
 * Assumes mje_defs.svh sits in the include path.
 */
`include "mje_defs.svh"

package mje_pkg;
   typedef enum logic [4:0] {
      op_index_load, op_index_store, op_double_load, op_double_store,
      op_move_a_to_b, op_move_b_to_a, op_move_a_to_index, op_move_index_to_a,
      op_move_a_to_y, op_move_y_to_a, op_store_to_addressed_register,
      op_load_from_addressed_register, op_long_exchange, op_long_load,
      op_long_store, op_y_load, op_y_store, op_conditional_short_store,
      op_conditional_long_store, op_compute_address, op_unconditional_jump,
      op_jump_and_store_return, op_jump_if_zero, op_jump_if_nonzero,
      op_jump_if_not_positive, op_jump_if_positive, op_jump_if_negative,
      op_jump_if_not_negative, op_decrement_index_jump, op_increment_index_jump
   } mje_op_e;
   typedef enum logic [1:0] {mode_16s, mode_32s, mode_32r, mode_64r} mje_mode_e;
   typedef enum logic [3:0] {
      st_idle = 4'b0001, st_read = 4'b0010, st_exec = 4'b0100, st_write = 4'b1000
   } mje_state_e;
   typedef struct packed {
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] x;
      logic [15:0] y;
      logic [31:0] e;
   } mje_regs_s;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        lock;
      logic [31:0] addr;
      logic [15:0] wdata;
   } mje_mem_req_s;
endpackage : mje_pkg

// >>> mje_mem_model.sv
/* word memory partner: 256 words, one-cycle ack per request.
   assumes each request holds until acked; i_dly sets the wait. */
`timescale 1ns/1ps
`default_nettype none
module mje_mem_model
   import mje_pkg::*;
(
   input  wire logic         i_clk,
   input  wire mje_mem_req_s i_mem,
   input  wire logic [3:0]   i_dly,
   output logic              o_ack,
   output logic [15:0]       o_rdata
);
   logic [15:0] ram [256];
   logic [3:0]  cnt = 4'h0;
   initial o_ack = 1'b0;
   initial o_rdata = 16'h0000;
   // acks only a visible request, never twice in a row; data toggles when idle
   always @(posedge i_clk) begin
      o_rdata <= ~o_rdata;
      o_ack <= 1'b0;
      if (i_mem.valid && !o_ack && cnt >= i_dly) begin
         o_ack <= 1'b1;
         cnt <= 4'h0;
         if (i_mem.write) ram[i_mem.addr[7:0]] <= i_mem.wdata;
         else o_rdata <= ram[i_mem.addr[7:0]];
      end else if (i_mem.valid && !o_ack) begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule : mje_mem_model
`default_nettype wire

// >>> mje_tb.sv
/* self-checking bench for mje_exec with the memory partner beside it.
   assumes i_start is taken at a rising edge while o_busy is low. */
`timescale 1ns/1ps
`default_nettype none
module tb
   import mje_pkg::*;
;
   logic         clk = 1'b0;
   logic         nrst = 1'b0;
   logic         start = 1'b0;
   logic         dm = 1'b0;
   logic         ix = 1'b0;
   logic         rs = 1'b0;
   logic [1:0]   ring = 2'h0;
   logic [3:0]   dly = 4'h0;
   logic [1:0]   rset = 2'h2;
   logic [31:0]  ea = 32'h0000_0000;
   logic [31:0]  pcn = 32'h0000_0100;
   mje_op_e      op = op_move_a_to_b;
   mje_mode_e    md = mode_16s;
   mje_mem_req_s mem;
   mje_regs_s    r;
   logic [15:0]  rd;
   logic [31:0]  pc;
   logic         ack, busy, done, ill, cc, inh;
   int           bad_count = 0, n_compared = 0, nolock = 0;
   mje_exec uut (.i_clk(clk), .i_nrst(nrst), .i_start(start), .i_op(op), .i_ea(ea), .i_pc_next(pcn),
      .i_ring(ring), .i_reg_set(rset), .i_addr_mode(md), .i_double_mode(dm), .i_index_req(ix),
      .i_restricted(rs), .i_mem_ack(ack), .i_mem_rdata(rd), .o_mem(mem), .o_regs(r), .o_pc(pc),
      .o_busy(busy), .o_done(done), .o_illegal(ill), .o_cc_eq(cc), .o_int_inhibit(inh));
   mje_mem_model m (.i_clk(clk), .i_mem(mem), .i_dly(dly), .o_ack(ack), .o_rdata(rd));
   always #25 clk = ~clk;
   // a channel could slip in wherever a conditional store drops its lock
   always @(negedge clk) if (busy && !mem.lock && op inside {op_conditional_short_store,
      op_conditional_long_store}) nolock++;
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one instruction, bounded wait for done
   task automatic run(input mje_op_e o, input logic [31:0] a);
      int k;
      // let an edge pass so start is never lowered and raised in one step
      @(negedge clk);
      op = o;
      ea = a;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      chk("done", 1'b1, done);
   endtask : run
   task automatic seta(input logic [15:0] v);
      m.ram[8'hff] = v;
      run(op_index_load, 32'h0000_00ff);
      run(op_move_index_to_a, 0);
   endtask : seta
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_move();
      m.ram[8'h10] = 16'h1234;
      run(op_index_load, 32'h0000_0010);
      chk("x", 16'h1234, r.x);
      run(op_index_store, 32'h0000_0011);
      chk("m11", 16'h1234, m.ram[8'h11]);
      ix = 1'b1;
      m.ram[8'h10] = 16'h5555;
      run(op_index_load, 32'h0000_0010);
      chk("ill", 1'b1, ill);
      ix = 1'b0;
      run(op_move_index_to_a, 0);
      run(op_move_a_to_y, 0);
      run(op_move_a_to_b, 0);
      run(op_y_store, 32'h0000_0012);
      chk("m12", 16'h1234, m.ram[8'h12]);
      m.ram[8'h13] = 16'h0bad;
      run(op_y_load, 32'h0000_0013);
      run(op_move_y_to_a, 0);
      run(op_move_a_to_index, 0);
      chk("x", 16'h0bad, r.x);
      run(op_move_b_to_a, 0);
      chk("a", 16'h1234, r.a);
   endtask : t_move
   // slow memory here: the far side stalls each word
   task automatic t_dbl();
      dly = 4'h3;
      m.ram[8'h20] = 16'haaaa;
      m.ram[8'h21] = 16'hbbbb;
      run(op_double_load, 32'h0000_0020);
      chk("ill", 1'b1, ill);
      chk("a", 16'h1234, r.a);
      dm = 1'b1;
      run(op_double_load, 32'h0000_0020);
      chk("l", 32'haaaa_bbbb, {r.a, r.b});
      run(op_double_store, 32'h0000_0022);
      chk("m22", 32'haaaa_bbbb, {m.ram[8'h22], m.ram[8'h23]});
      dm = 1'b0;
      dly = 4'h0;
   endtask : t_dbl
   task automatic t_long();
      run(op_long_exchange, 0);
      chk("e", 32'haaaa_bbbb, r.e);
      m.ram[8'h30] = 16'h1111;
      m.ram[8'h31] = 16'h2222;
      run(op_long_load, 32'h0000_0030);
      chk("l", 32'h1111_2222, {r.a, r.b});
      m.ram[8'h34] = 16'haaaa;
      m.ram[8'h35] = 16'hbbbb;
      run(op_conditional_long_store, 32'h0000_0034);
      chk("m34", 32'h1111_2222, {m.ram[8'h34], m.ram[8'h35]});
      m.ram[8'h40] = 16'h2222;
      run(op_conditional_short_store, 32'h0000_0040);
      chk("m40", 16'h1111, m.ram[8'h40]);
      chk("cc", 1'b1, cc);
      m.ram[8'h40] = 16'h3333;
      run(op_conditional_short_store, 32'h0000_0040);
      chk("m40", 16'h3333, m.ram[8'h40]);
      chk("cc", 1'b0, cc);
   endtask : t_long
   task automatic t_rf();
      run(op_store_to_addressed_register, 32'h0000_4045);
      run(op_long_exchange, 0);
      run(op_load_from_addressed_register, 32'h0000_0005);
      chk("l", 32'h1111_2222, {r.a, r.b});
      run(op_move_b_to_a, 0);
      ring = 2'h1;
      run(op_load_from_addressed_register, 32'h0000_0005);
      chk("l", 32'h1111_2222, {r.a, r.b});
      run(op_store_to_addressed_register, 32'h0000_0015);
      chk("ill", 1'b1, ill);
      ring = 2'h0;
      rset = 2'h1;
      run(op_store_to_addressed_register, 32'h0000_0003);
      run(op_move_b_to_a, 0);
      rset = 2'h2;
      run(op_load_from_addressed_register, 32'h0000_4023);
      chk("l", 32'h1111_2222, {r.a, r.b});
   endtask : t_rf
   task automatic t_jmp();
      logic [5:0]  tk;
      logic [15:0] v;
      run(op_unconditional_jump, 32'h0000_0050);
      chk("pc", 32'h0000_0050, pc);
      for (int k = 0; k < 3; k++) begin
         v = (k == 0) ? 16'h0000 : ((k == 1) ? 16'h0001 : 16'h8000);
         seta(v);
         tk = {v == 0, v != 0, v == 0 || v[15], v != 0 && !v[15], v[15], !v[15]};
         for (int i = 0; i < 6; i++) begin
            run(mje_op_e'(op_jump_if_zero + i), 32'h0000_0060);
            chk("pc", tk[5 - i] ? 32'h0000_0060 : pcn, pc);
         end
      end
      pcn = 32'h0000_0200;
      seta(16'h0001);
      run(op_decrement_index_jump, 32'h0000_0060);
      chk("pc", pcn, pc);
      run(op_decrement_index_jump, 32'h0000_0061);
      chk("pc", 32'h0000_0061, pc);
      run(op_increment_index_jump, 32'h0000_0062);
      chk("pc", pcn, pc);
      run(op_increment_index_jump, 32'h0000_0063);
      chk("pc", 32'h0000_0063, pc);
      chk("x", 16'h0001, r.x);
      pcn = 32'h0000_9678;
      for (int n = 0; n < 4; n++) begin
         md = mje_mode_e'(n);
         rs = (n == 3);
         m.ram[8'h70] = 16'h4000;
         run(op_move_a_to_b, 0);
         run(op_jump_and_store_return, 32'h0000_0070);
         chk("pc", 32'h0000_0071, pc);
         chk("inh", !rs, inh);
         chk("ret", n == 0 ? 16'h5678 : (n == 3 ? 16'h9678 : 16'h1678), m.ram[8'h70]);
         @(negedge clk);
         chk("inh_hold", !rs, inh);
      end
      rs = 1'b0;
   endtask : t_jmp
   task automatic t_cea();
      md = mode_16s;
      seta(16'h7234);
      run(op_compute_address, 0);
      chk("a", 16'h3234, r.a);
      md = mode_32s;
      m.ram[8'h50] = 16'h0123;
      seta(16'h8050);
      run(op_compute_address, 0);
      chk("a", 16'h0123, r.a);
   endtask : t_cea
   initial begin
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      t_move();
      t_dbl();
      t_long();
      t_rf();
      t_jmp();
      t_cea();
      chk("lock", 0, nolock);
      finish_test();
   end
   // watchdog: about forty times the expected run
   initial begin
      #500_000;
      bad_count++;
      finish_test();
   end
endmodule : tb
`default_nettype wire
